/* File: passive_serial_config_sequencing_test.sv */
// Purpose: Self-checking bench, host and device joined by the link
// Assumes: 50 MHz mclk, fixed random seed
// Notes:   Full-length counts; whole run stays near 91000 cycles
module passive_serial_config_sequencing_test
    import psc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic       mclk;
    logic       sys_rst;
    logic       startCfg;
    logic       useUserClock;
    logic       srcValid;
    logic [7:0] srcData;
    logic       byteReady;
    logic       stallLong;
    logic       busy;
    logic       failed;
    logic       srcReady;
    logic [7:0] byteData;
    logic       byteValid;
    logic       userMode;
    logic [7:0] wireShift;
    logic       clkPrev;
    logic [7:0] wireExp[$];
    logic [7:0] rxExp[$];
    int         wireBits;
    int         fails;
    int         total_checks;
    int         seed;

    psc_link_if link();
    psc_host psc_host_inst (.mclk(mclk), .sys_rst(sys_rst), .startCfg(startCfg), .busy(busy),
        .failed(failed), .srcData(srcData), .srcValid(srcValid), .srcReady(srcReady), .link(link));
    psc_device psc_device_inst (.mclk(mclk), .sys_rst(sys_rst), .useUserClock(useUserClock), .link(link),
        .byteData(byteData), .byteValid(byteValid), .byteReady(byteReady), .userMode(userMode));
    psc_link_checker psc_link_checker_inst (.mclk(mclk), .sys_rst(sys_rst),
        .reconfigRequestN(link.reconfigRequestN), .serialCfgClock(link.serialCfgClock),
        .serialData(link.serialData), .userStartupClock(link.userStartupClock), .statusOe(link.statusOe),
        .doneOe(link.doneOe), .cfgReadyErrorN(link.cfgReadyErrorN), .loadComplete(link.loadComplete));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
            fails++;
        end
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Rebuild bytes from the wire, first bit is bit 0
    always @(posedge mclk)
    begin
        if (link.reconfigRequestN !== 1'b1)
            wireBits = 0;
        else if (link.serialCfgClock === 1'b1 && clkPrev === 1'b0 && wireExp.size() > 0)
        begin
            wireShift = {link.serialData, wireShift[7:1]};
            wireBits++;
            if (wireBits == DATA_BITS)
            begin
                check("wire byte", {24'h000000, wireExp.pop_front()}, {24'h000000, wireShift});
                wireBits = 0;
            end
        end
        clkPrev = link.serialCfgClock;
    end

    // Receiver with random stalls; one long stall of one byte time holds a byte in the buffer
    always @(posedge mclk)
    begin
        if (byteValid === 1'b1 && byteReady === 1'b1 && rxExp.size() > 0)
            check("received byte", {24'h000000, rxExp.pop_front()}, {24'h000000, byteData});
        byteReady <= stallLong ? 1'b0 : ($random(seed) % 4 != 0);
    end

    task automatic run_cfg(input logic badEnd, input logic userClk);
        logic [7:0] b;
        logic       prevU;
        int         n;
        int         rises;
        n = 0;
        while (busy !== 1'b0 && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        wireExp.delete();
        rxExp.delete();
        useUserClock <= userClk;
        startCfg <= 1'b1;
        @(posedge mclk);
        startCfg <= 1'b0;
        for (int i = 0; i < LOAD_BYTES; i++)
        begin
            b = $random(seed);
            if (i == LOAD_BYTES - 1)
                b = badEnd ? (b & 8'h7F) : LOAD_LAST;
            wireExp.push_back(b);
            rxExp.push_back(b);
            srcData <= b;
            srcValid <= 1'b1;
            stallLong <= (i == 4);
            n = 0;
            do
            begin
                @(posedge mclk);
                n++;
            end
            while (srcReady !== 1'b1 && n < 20000);
            check("byte taken", 1'b1, srcReady);
        end
        srcValid <= 1'b0;
        stallLong <= 1'b0;
        n = 0;
        while ((badEnd ? busy !== 1'b0 : link.loadComplete !== 1'b1) && n < 2000)
        begin
            @(posedge mclk);
            n++;
        end
        if (badEnd)
        begin
            check("host failure flag", 1'b1, failed);
            check("done on bad load", 1'b0, link.loadComplete);
            check("user mode on bad load", 1'b0, userMode);
        end
        else
        begin
            check("done after full load", 1'b1, link.loadComplete);
            n = 0;
            rises = 0;
            prevU = link.userStartupClock;
            while (userMode !== 1'b1 && n < 40000)
            begin
                @(posedge mclk);
                n++;
                if (link.userStartupClock === 1'b1 && prevU === 1'b0)
                    rises++;
                prevU = link.userStartupClock;
            end
            if (userClk)
                check("user clock periods", 1'b1, rises >= USER_CLK_PERIODS && rises <= USER_CLK_PERIODS + 8);
            else
                check("oscillator start-up", 1'b1, n >= OSC_MIN_US * 50 && n <= OSC_MAX_US * 50);
            repeat (2) @(posedge mclk);
            check("user mode status", 1'b1, link.cfgReadyErrorN);
            check("user mode done", 1'b1, link.loadComplete);
            check("user mode request", 1'b1, link.reconfigRequestN);
            check("data line driven", 1'b1, link.serialData === 1'b0 || link.serialData === 1'b1);
            check("no failure flag", 1'b0, failed);
            check("all bytes delivered", 1'b1, rxExp.size() == 0);
        end
    endtask

    // Whole run is near 91000 cycles
    initial
    begin
        repeat (99000) @(posedge mclk);
        fails++;
        $display("ERROR watchdog expected finish seen timeout");
        conclude();
    end

    initial
    begin
        int n;
        seed = 86488;
        sys_rst = 1'b1;
        startCfg = 1'b0;
        useUserClock = 1'b0;
        srcValid = 1'b0;
        srcData = 8'h00;
        byteReady = 1'b0;
        stallLong = 1'b0;
        wireShift = 8'h00;
        clkPrev = 1'b0;
        wireBits = 0;
        fails = 0;
        total_checks = 0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (4000) @(posedge mclk);
        check("power-on status", 1'b0, link.cfgReadyErrorN);
        check("done before load", 1'b0, link.loadComplete);
        n = 4000;
        while (link.cfgReadyErrorN !== 1'b1 && n < 9000)
        begin
            @(posedge mclk);
            n++;
        end
        check("power-on low time", 1'b1, n >= POR_CYC + STATUS_LOW_CYC && n < 9000);
        run_cfg(1'b1, 1'b0);
        run_cfg(1'b0, 1'b0);
        run_cfg(1'b0, 1'b1);
        conclude();
    end
endmodule

/* File: psc_device.sv */
// Purpose: Configuration port of the documented device
// Assumes: Host drives request, clock and data; pins sampled by mclk
// Notes:   Fixed-length bitstream of LOAD_BYTES bytes, last byte LOAD_LAST
// Summary of operation
// - Request low drives status, done low quickly
// - User mode lines high; status low during POR
// - Done stays low until load completes
// - Own status low pulse at least 45 us
// - Host waits 230 us before first clock
// - Host waits 2 us after status high
// - Oscillator start-up: user mode 300-650 us
// - Host runs user start-up clock promptly
// - User clock start-up: 3192 periods
// - Host keeps serial clock below maximum
// - Host holds serial clock steady in user mode
// - No one drives clock in active scheme
// - Host drives data line after configuration
// - Device samples data on rising clock
// - Host sends bytes least bit first
// - Host gives two falls after done
// - Host restarts when done never rises; this host only sets failed and returns to idle
module psc_device
    import psc_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Start-up option
    input  wire logic useUserClock,
    // Link
    psc_link_if.device link,
    // User side
    output logic [7:0] byteData,
    output logic       byteValid,
    input  wire logic  byteReady,
    output logic       userMode
);
    typedef enum logic [4:0]
    {
        ST_RESET = 5'b00001,
        ST_LOAD  = 5'b00010,
        ST_INIT  = 5'b00100,
        ST_START = 5'b01000,
        ST_USER  = 5'b10000
    } psc_dev_state_t;

    psc_dev_state_t state_reg;
    logic [2:0]  reqSync_reg;
    logic [2:0]  sclkSync_reg;
    logic [1:0]  dataSync_reg;
    logic [2:0]  uclkSync_reg;
    logic [22:0] timer_reg;
    logic [11:0] uclkCnt_reg;
    logic [7:0]  shift_reg;
    logic [BIT_CNT_W-1:0] bitCnt_reg;
    logic [4:0]  byteCnt_reg;
    logic [1:0]  fallCnt_reg;
    logic        porDone_reg;
    logic        reqN;
    logic        sclkRise;
    logic        sclkFall;
    logic        uclkRise;
    logic        bitIn;
    logic [7:0]  shift_next;
    logic        wordStrobe;
    logic        bufReady;

    assign reqN       = reqSync_reg[1];
    assign sclkRise   = sclkSync_reg[1] & ~sclkSync_reg[2];
    assign sclkFall   = ~sclkSync_reg[1] & sclkSync_reg[2];
    assign uclkRise   = uclkSync_reg[1] & ~uclkSync_reg[2];
    assign bitIn      = dataSync_reg[1];
    assign shift_next = {bitIn, shift_reg[7:1]};
    assign wordStrobe = (state_reg == ST_LOAD) && sclkRise && link.cfgReadyErrorN
                        && (bitCnt_reg == BIT_CNT_W'(DATA_BITS - 1));

    // Pins cross two flops before use
    always_ff @(posedge mclk)
    begin
        reqSync_reg  <= {reqSync_reg[1:0], link.reconfigRequestN};
        sclkSync_reg <= {sclkSync_reg[1:0], link.serialCfgClock};
        dataSync_reg <= {dataSync_reg[0], link.serialData};
        uclkSync_reg <= {uclkSync_reg[1:0], link.userStartupClock};
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_reg   <= ST_RESET;
            timer_reg   <= '0;
            porDone_reg <= 1'b0;
            uclkCnt_reg <= '0;
            fallCnt_reg <= '0;
            link.statusOe <= 1'b1;
            link.doneOe   <= 1'b1;
            userMode    <= 1'b0;
        end
        else if (!reqN && porDone_reg)
        begin
            // Sync delay keeps response well under 500 ns
            state_reg     <= ST_RESET;
            timer_reg     <= '0;
            link.statusOe <= 1'b1;
            link.doneOe   <= 1'b1;
            userMode      <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_RESET:
                begin
                    timer_reg <= timer_reg + 23'd1;
                    // Status held for POR first, then for the minimum pulse
                    if (!porDone_reg && timer_reg >= 23'(POR_CYC - 1))
                    begin
                        porDone_reg <= 1'b1;
                        timer_reg   <= '0;
                    end
                    else if (porDone_reg && reqN && timer_reg >= 23'(STATUS_LOW_CYC - 1))
                    begin
                        link.statusOe <= 1'b0;
                        state_reg     <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    if (wordStrobe && byteCnt_reg == 5'(LOAD_BYTES - 1))
                    begin
                        if (shift_next == LOAD_LAST)
                        begin
                            link.doneOe <= 1'b0;
                            fallCnt_reg <= '0;
                            state_reg   <= ST_INIT;
                        end
                        else
                        begin
                            link.statusOe <= 1'b1; // Bad stream flags error
                        end
                    end
                end
                ST_INIT:
                begin
                    if (sclkFall)
                        fallCnt_reg <= fallCnt_reg + 2'd1;
                    if (fallCnt_reg == 2'(TRAILING_FALLS))
                    begin
                        timer_reg   <= '0;
                        uclkCnt_reg <= '0;
                        state_reg   <= ST_START;
                    end
                end
                ST_START:
                begin
                    timer_reg <= timer_reg + 23'd1;
                    if (uclkRise)
                        uclkCnt_reg <= uclkCnt_reg + 12'd1;
                    if (!useUserClock && timer_reg >= 23'(OSC_USERMODE_CYC - 1))
                        state_reg <= ST_USER;
                    if (useUserClock && uclkCnt_reg == 12'(USER_CLK_PERIODS))
                        state_reg <= ST_USER;
                end
                ST_USER:
                begin
                    userMode <= 1'b1;
                end
            endcase
        end
    end

    // Bit and byte assembly
    always_ff @(posedge mclk)
    begin
        if (sys_rst || state_reg != ST_LOAD)
        begin
            bitCnt_reg  <= '0;
            byteCnt_reg <= '0;
            shift_reg   <= '0;
        end
        else if (sclkRise && link.cfgReadyErrorN)
        begin
            shift_reg  <= shift_next;
            bitCnt_reg <= bitCnt_reg + BIT_CNT_W'(1);
            if (wordStrobe)
                byteCnt_reg <= byteCnt_reg + 5'd1;
        end
    end

    // Two-entry output buffer; overflow only if user stalls for 16 serial clocks
    logic [7:0] buf0_reg;
    logic [7:0] buf1_reg;
    logic [1:0] bufCnt_reg;
    logic       popNow;
    assign bufReady = (bufCnt_reg != 2'd2);
    assign popNow   = byteValid && byteReady;
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            bufCnt_reg <= '0;
            buf0_reg   <= '0;
            buf1_reg   <= '0;
            byteValid  <= 1'b0;
        end
        else
        begin
            unique case ({wordStrobe && bufReady, popNow})
                2'b10:
                begin
                    if (bufCnt_reg == 2'd0)
                        buf0_reg <= shift_next;
                    else
                        buf1_reg <= shift_next;
                    bufCnt_reg <= bufCnt_reg + 2'd1;
                    byteValid  <= 1'b1;
                end
                2'b01:
                begin
                    buf0_reg   <= buf1_reg;
                    bufCnt_reg <= bufCnt_reg - 2'd1;
                    byteValid  <= (bufCnt_reg == 2'd2);
                end
                2'b11:
                begin
                    buf0_reg <= (bufCnt_reg == 2'd1) ? shift_next : buf1_reg;
                    buf1_reg <= shift_next;
                end
                default:
                begin
                end
            endcase
        end
    end
    // Valid kept in a flop so the output is registered
    assign byteData = buf0_reg;
endmodule

/* File: psc_host.sv */
// Purpose: External host feeding the configuration bitstream
// Assumes: Bytes supplied with valid/ready; serial clock made by divider
// Notes:   Serial clock is mclk/8, far below the device maximum
module psc_host
    import psc_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // Control
    input  wire logic startCfg,
    output logic      busy,
    output logic      failed,
    // Byte stream
    input  wire logic [7:0] srcData,
    input  wire logic       srcValid,
    output logic            srcReady,
    // Link
    psc_link_if.host link
);
    typedef enum logic [5:0]
    {
        H_IDLE  = 6'b000001,
        H_REQ   = 6'b000010,
        H_WAIT  = 6'b000100,
        H_SHIFT = 6'b001000,
        H_TAIL  = 6'b010000,
        H_DONE  = 6'b100000
    } psc_host_state_t;

    psc_host_state_t state_reg;
    logic [1:0]  stSync_reg;
    logic [1:0]  cdSync_reg;
    logic [22:0] timer_reg;
    logic [22:0] stTimer_reg;
    logic [2:0]  div_reg;
    logic [7:0]  shift_reg;
    logic [3:0]  bitCnt_reg;
    logic [4:0]  byteCnt_reg;
    logic [1:0]  fallCnt_reg;
    logic        halfTick;

    assign halfTick = (div_reg == 3'(SCLK_HALF_CYC - 1));

    always_ff @(posedge mclk)
    begin
        stSync_reg <= {stSync_reg[0], link.cfgReadyErrorN};
        cdSync_reg <= {cdSync_reg[0], link.loadComplete};
        // Divider needs a reset, an unknown count never ticks
        if (sys_rst)
            div_reg <= 3'd0;
        else
            div_reg <= halfTick ? 3'd0 : div_reg + 3'd1;
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_reg             <= H_IDLE;
            link.reconfigRequestN <= 1'b1;
            link.serialCfgClock   <= 1'b0;
            link.serialData       <= 1'b0;
            link.userStartupClock <= 1'b0;
            timer_reg   <= '0;
            stTimer_reg <= '0;
            shift_reg   <= '0;
            bitCnt_reg  <= '0;
            byteCnt_reg <= '0;
            fallCnt_reg <= '0;
            srcReady    <= 1'b0;
            busy        <= 1'b0;
            failed      <= 1'b0;
        end
        else
        begin
            srcReady <= 1'b0;
            if (halfTick)
                link.userStartupClock <= ~link.userStartupClock;
            unique case (state_reg)
                H_IDLE:
                begin
                    if (startCfg)
                    begin
                        link.reconfigRequestN <= 1'b0;
                        timer_reg <= '0;
                        busy      <= 1'b1;
                        failed    <= 1'b0;
                        state_reg <= H_REQ;
                    end
                end
                H_REQ:
                begin
                    timer_reg <= timer_reg + 23'd1;
                    if (timer_reg >= 23'(REQ_LOW_CYC - 1))
                    begin
                        link.reconfigRequestN <= 1'b1;
                        timer_reg   <= '0;
                        stTimer_reg <= '0;
                        state_reg   <= H_WAIT;
                    end
                end
                H_WAIT:
                begin
                    timer_reg <= timer_reg + 23'd1;
                    stTimer_reg <= stSync_reg[1] ? stTimer_reg + 23'd1 : '0;
                    if (timer_reg >= 23'(REQ_TO_CLK_CYC) && stTimer_reg >= 23'(READY_TO_CLK_CYC))
                    begin
                        bitCnt_reg  <= '0;
                        byteCnt_reg <= '0;
                        state_reg   <= H_SHIFT;
                    end
                end
                H_SHIFT:
                begin
                    if (!stSync_reg[1])
                    begin
                        failed    <= 1'b1;
                        busy      <= 1'b0;
                        state_reg <= H_IDLE;
                    end
                    else if (halfTick)
                    begin
                        if (link.serialCfgClock)
                        begin
                            // Data moves on the fall, a half period before the rise
                            link.serialCfgClock <= 1'b0;
                            if (bitCnt_reg != 4'd0)
                            begin
                                link.serialData <= shift_reg[0];
                                shift_reg       <= {1'b0, shift_reg[7:1]};
                            end
                        end
                        else if (bitCnt_reg != 4'd0)
                        begin
                            link.serialCfgClock <= 1'b1;
                            bitCnt_reg          <= bitCnt_reg - 4'd1;
                        end
                        else if (byteCnt_reg == 5'(LOAD_BYTES))
                        begin
                            fallCnt_reg <= '0;
                            state_reg   <= H_TAIL;
                        end
                        else if (srcValid)
                        begin
                            srcReady        <= 1'b1;
                            link.serialData <= srcData[0];
                            shift_reg       <= {1'b0, srcData[7:1]};
                            bitCnt_reg      <= 4'(DATA_BITS);
                            byteCnt_reg     <= byteCnt_reg + 5'd1;
                        end
                    end
                end
                H_TAIL:
                begin
                    if (halfTick)
                    begin
                        link.serialCfgClock <= ~link.serialCfgClock;
                        if (link.serialCfgClock)
                            fallCnt_reg <= fallCnt_reg + 2'd1;
                    end
                    if (fallCnt_reg == 2'(TRAILING_FALLS))
                    begin
                        failed    <= ~cdSync_reg[1];
                        state_reg <= H_DONE;
                    end
                end
                H_DONE:
                begin
                    busy <= 1'b0;
                    link.serialCfgClock <= 1'b0;
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: psc_link_checker.sv */
// Purpose: Timing checks on the configuration link wires
// Assumes: Both ends are design code, sampled by mclk
// Notes:   Saturating counters keep long waits off the assertions
module psc_link_checker
    import psc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Host driven
    input wire logic reconfigRequestN,
    input wire logic serialCfgClock,
    input wire logic serialData,
    input wire logic userStartupClock,
    // Device driven
    input wire logic statusOe,
    input wire logic doneOe,
    input wire logic cfgReadyErrorN,
    input wire logic loadComplete
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] reqLowCnt_reg;
    logic [15:0] sinceReqHigh_reg;
    logic [15:0] sinceReady_reg;
    logic [15:0] statusLowCnt_reg;
    logic [7:0]  riseCnt_reg;
    logic [1:0]  fallCnt_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    function automatic logic [15:0] sat(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    // Time since link events
    always_ff @(posedge mclk)
    begin
        reqLowCnt_reg    <= (sys_rst || reconfigRequestN) ? 16'h0000 : sat(reqLowCnt_reg);
        sinceReqHigh_reg <= (sys_rst || !reconfigRequestN) ? 16'h0000 : sat(sinceReqHigh_reg);
        sinceReady_reg   <= (sys_rst || !cfgReadyErrorN) ? 16'h0000 : sat(sinceReady_reg);
        statusLowCnt_reg <= (sys_rst || cfgReadyErrorN) ? 16'h0000 : sat(statusLowCnt_reg);
    end

    // Serial clock edges; cleared by request or done low
    always_ff @(posedge mclk)
    begin
        if (sys_rst || !reconfigRequestN)
            riseCnt_reg <= 8'h00;
        else if ($rose(serialCfgClock) && riseCnt_reg != 8'hFF)
            riseCnt_reg <= riseCnt_reg + 8'h01;
        if (sys_rst || !loadComplete)
            fallCnt_reg <= 2'h0;
        else if ($fell(serialCfgClock) && fallCnt_reg != 2'h3)
            fallCnt_reg <= fallCnt_reg + 2'h1;
    end

    a_req_pulls_low: assert property ($fell(reconfigRequestN) |-> ##[1:25] (statusOe && doneOe))
        else $error("status or done not pulled low after request");
    a_req_low_width: assert property ($rose(reconfigRequestN) |-> reqLowCnt_reg >= REQ_LOW_CYC)
        else $error("request low pulse too short");
    a_done_after_load: assert property ($rose(loadComplete) |-> riseCnt_reg == LOAD_BYTES * DATA_BITS)
        else $error("done released before full bitstream");
    a_status_min_low: assert property ($rose(cfgReadyErrorN) |-> statusLowCnt_reg >= STATUS_LOW_CYC)
        else $error("status low pulse too short");
    a_req_to_clock: assert property ($rose(serialCfgClock) |-> sinceReqHigh_reg >= REQ_TO_CLK_CYC)
        else $error("serial clock too soon after request");
    a_ready_to_clock: assert property ($rose(serialCfgClock) |-> sinceReady_reg >= READY_TO_CLK_CYC)
        else $error("serial clock too soon after status high");
    a_trailing_falls: assert property ($rose(loadComplete) |-> ##[1:40] (fallCnt_reg == 2'h2))
        else $error("two trailing falls missing after done");
    a_clock_steady: assert property ((fallCnt_reg == 2'h3) |=> $stable(serialCfgClock))
        else $error("serial clock moved in user mode");
    a_data_before_rise: assert property ($rose(serialCfgClock) |-> $stable(serialData))
        else $error("serial data changed with the rising clock");
    a_idle_on_error: assert property ((!cfgReadyErrorN) [*8] |-> !$rose(serialCfgClock))
        else $error("serial clock ran while status low");
endmodule

/* File: psc_link_if.sv */
// Purpose: Pin bundle between configuration host and device
// Assumes: Open-drain status and done lines with pull-ups
// Notes:   Wire levels resolved here from output enables
interface psc_link_if;
    logic reconfigRequestN;
    logic serialCfgClock;
    logic serialData;
    logic userStartupClock;
    logic statusOe;
    logic doneOe;
    logic cfgReadyErrorN;
    logic loadComplete;
    // Open drain: enable high pulls low, otherwise pull-up wins
    assign cfgReadyErrorN = ~statusOe;
    assign loadComplete   = ~doneOe;
    modport host
    (
        output reconfigRequestN, serialCfgClock, serialData, userStartupClock,
        input  cfgReadyErrorN, loadComplete
    );
    modport device
    (
        input  reconfigRequestN, serialCfgClock, serialData, userStartupClock,
        output statusOe, doneOe,
        input  cfgReadyErrorN, loadComplete
    );
endinterface

/* File: psc_pkg.sv */
// Purpose: Shared constants for the passive serial configuration link
// Assumes: 50 MHz mclk, 20 ns period
// Notes:   Times in their own units, cycle counts derived from them
package psc_pkg;
    localparam int CLK_NS             = 20;
    localparam int REQ_LOW_NS         = 500;
    localparam int REQ_LOW_CYC        = (REQ_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int STATUS_LOW_US      = 45;
    localparam int STATUS_LOW_CYC     = (STATUS_LOW_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int POR_US             = 100;
    localparam int POR_CYC            = (POR_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int REQ_TO_CLK_US      = 230;
    localparam int REQ_TO_CLK_CYC     = (REQ_TO_CLK_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int READY_TO_CLK_US    = 2;
    localparam int READY_TO_CLK_CYC   = (READY_TO_CLK_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int OSC_MIN_US         = 300;
    localparam int OSC_MAX_US         = 650;
    localparam int OSC_USERMODE_US    = 400;
    localparam int OSC_USERMODE_CYC   = (OSC_USERMODE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int USER_CLK_PERIODS   = 3192;
    localparam int DATA_BITS          = 8;
    localparam int BIT_CNT_W          = 3;
    localparam int TRAILING_FALLS     = 2;
    localparam int SCLK_HALF_CYC      = 4;
    localparam int LOAD_BYTES         = 16;
    localparam logic [7:0] LOAD_LAST  = 8'hFF;
endpackage
